//--- design/flash_bus_cycle.sv
`include "flash_host_consts.svh"
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // system
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // request
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [`FL_ADDR_W-1:0] addr_in,
    input wire logic [`FL_DATA_W-1:0] wdata_in,
    output logic busy_out,
    output logic done_out,
    output logic [`FL_DATA_W-1:0] rdata_out,
    // flash pins
    output logic [`FL_ADDR_W-1:0] fl_addr_out,
    output logic fl_ce_n_out,
    output logic fl_we_n_out,
    output logic fl_oe_n_out,
    output logic [`FL_DATA_W-1:0] fl_dq_out,
    output logic fl_dq_oe_out,
    input wire logic [`FL_DATA_W-1:0] fl_dq_in
);
    localparam logic [1:0] STEP_LAST = 2'(`STEP_CYCLES - 1);
    localparam logic [1:0] STROBE_LAST = 2'(`STROBE_STEPS - 1);

    cyc_state_e state;
    logic [1:0] div;
    logic [1:0] nstep;
    logic is_write;
    logic [`FL_DATA_W-1:0] dq_s1;
    logic [`FL_DATA_W-1:0] dq_s2;
    logic [`FL_DATA_W-1:0] dq_s3;
    logic [`FL_DATA_W-1:0] dq_settled;
    wire step = (div == STEP_LAST);
    // value the settled word takes at this edge; the flop itself lags one
    wire [`FL_DATA_W-1:0] next_settled = (dq_s2 == dq_s3) ? dq_s3 : dq_settled;

    assign busy_out = (state != CYC_IDLE);
    assign done_out = (state == CYC_HOLD) && step;

    // divider restarts with each cycle so phase lengths are fixed
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            div <= 2'h0;
        else if (state == CYC_IDLE || step)
            div <= 2'h0;
        else
            div <= 2'(div + 2'h1);
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dq_s3 <= '0;
            dq_settled <= '0;
        end
        else
        begin
            dq_s1 <= fl_dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            dq_settled <= next_settled;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= CYC_IDLE;
            nstep <= 2'h0;
            is_write <= 1'b0;
            fl_addr_out <= '0;
            fl_dq_out <= '0;
            fl_dq_oe_out <= 1'b0;
            fl_ce_n_out <= 1'b1;
            fl_we_n_out <= 1'b1;
            fl_oe_n_out <= 1'b1;
            rdata_out <= '0;
        end
        else
        begin
            case (state)
                CYC_IDLE:
                    if (start_in)
                    begin
                        fl_addr_out <= addr_in;
                        fl_dq_out <= wdata_in;
                        fl_dq_oe_out <= write_in;
                        is_write <= write_in;
                        fl_ce_n_out <= 1'b0;
                        state <= CYC_SETUP;
                    end
                CYC_SETUP:
                    if (step)
                    begin
                        fl_we_n_out <= ~is_write;
                        fl_oe_n_out <= is_write;
                        nstep <= 2'h0;
                        state <= CYC_STROBE;
                    end
                CYC_STROBE:
                    if (step)
                    begin
                        if (nstep == STROBE_LAST)
                        begin
                            fl_we_n_out <= 1'b1;
                            fl_oe_n_out <= 1'b1;
                            // settled flop is one edge late at strobe end
                            if (!is_write)
                                rdata_out <= next_settled;
                            state <= CYC_HOLD;
                        end
                        else
                            nstep <= 2'(nstep + 2'h1);
                    end
                CYC_HOLD:
                    // data and address held past the strobe edge
                    if (step)
                    begin
                        fl_ce_n_out <= 1'b1;
                        fl_dq_oe_out <= 1'b0;
                        state <= CYC_IDLE;
                    end
                default:
                    state <= CYC_IDLE;
            endcase
        end
    end
endmodule // flash_bus_cycle
`default_nettype wire

//--- design/flash_host_ctrl.sv
`include "flash_host_consts.svh"
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // system
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    // flash pins
    output logic [`FL_ADDR_W-1:0] fl_addr_out,
    output logic fl_ce_n_out,
    output logic fl_we_n_out,
    output logic fl_oe_n_out,
    output logic [`FL_DATA_W-1:0] fl_dq_out,
    output logic fl_dq_oe_out,
    input wire logic [`FL_DATA_W-1:0] fl_dq_in,
    input wire logic fl_ready_in
);
    localparam int NB = `NUM_BANKS;

    seq_state_e seq;
    logic [2:0] cmd_q;
    logic [1:0] bank_q;
    logic [1:0] step_q;
    logic [`FL_ADDR_W-1:0] addr_reg;
    logic [`FL_DATA_W-1:0] wdata_reg;
    logic [`FL_DATA_W-1:0] rdata_reg;
    logic need_reset;
    logic refused;
    logic sig_err;
    logic rdy_s1;
    logic rdy_s2;
    logic rdy_s3;
    logic ready_q;
    logic [NB-1:0] auto_v;
    logic [NB-1:0] query_v;
    logic [NB-1:0] susp_v;

    // {write, address, data} of one bus cycle of a command
    function automatic logic [38:0] cmd_step(input logic [2:0] cmd,
        input logic [1:0] stp, input logic [1:0] bank,
        input logic [`FL_ADDR_W-1:0] a, input logic [`FL_DATA_W-1:0] d);
        logic [`FL_ADDR_W-1:0] bank_addr;
        bank_addr = `FL_UNLOCK1_ADDR | {bank, 20'h00000};
        case (cmd)
            `CMD_RESET: cmd_step = {1'b1, a, `FL_RESET_DATA};
            `CMD_QUERY: cmd_step = {1'b1, `FL_QUERY_ADDR, `FL_QUERY_DATA};
            `CMD_WRITE: cmd_step = {1'b1, a, d};
            `CMD_AUTOSEL:
                if (stp == 2'h0)
                    cmd_step = {1'b1, `FL_UNLOCK1_ADDR, `FL_UNLOCK1_DATA};
                else if (stp == 2'h1)
                    cmd_step = {1'b1, `FL_UNLOCK2_ADDR, `FL_UNLOCK2_DATA};
                else
                    cmd_step = {1'b1, bank_addr, `FL_AUTOSEL_DATA};
            default: cmd_step = {1'b0, a, 16'h0000};
        endcase
    endfunction

    // {check mask, expected word} of the extended query table
    function automatic logic [31:0] query_expect(input logic [7:0] off);
        case (off)
            8'h40: query_expect = {16'hffff, 16'h0050};
            8'h41: query_expect = {16'hffff, 16'h0052};
            8'h42: query_expect = {16'hffff, 16'h0049};
            8'h43: query_expect = {16'hffff, 16'h0031};
            8'h44: query_expect = {16'hffff, 16'h0033};
            8'h45: query_expect = {16'h0003, 16'h0000};
            8'h46: query_expect = {16'hffff, 16'h0002};
            8'h47: query_expect = {16'hffff, 16'h0001};
            8'h48: query_expect = {16'hffff, 16'h0001};
            8'h4a: query_expect = {16'hffff, 16'h0077};
            8'h4b: query_expect = {16'hffff, 16'h0000};
            8'h4c: query_expect = {16'hffff, 16'h0000};
            8'h4d: query_expect = {16'hffff, 16'h0085};
            8'h4e: query_expect = {16'hffff, 16'h0095};
            8'h4f: query_expect = {16'hffff, 16'h0001};
            8'h50: query_expect = {16'hffff, 16'h0001};
            8'h57: query_expect = {16'hffff, 16'h0004};
            8'h58: query_expect = {16'hffff, 16'h0017};
            8'h59: query_expect = {16'hffff, 16'h0030};
            8'h5a: query_expect = {16'hffff, 16'h0030};
            8'h5b: query_expect = {16'hffff, 16'h0017};
            default: query_expect = 32'h00000000;
        endcase
    endfunction

    // register decode
    wire wr_ctrl = bus_wr_in && bus_addr_in == `REG_CTRL;
    wire wr_addr = bus_wr_in && bus_addr_in == `REG_ADDR;
    wire wr_wdata = bus_wr_in && bus_addr_in == `REG_WDATA;
    wire wr_status = bus_wr_in && bus_addr_in == `REG_STATUS;
    wire [2:0] new_cmd = bus_wdata_in[2:0];
    wire [1:0] new_bank = bus_wdata_in[`CTRL_BANK_LSB +: 2];
    wire any_special = |(auto_v | query_v);

    // command acceptance
    wire cmd_ok = (seq == SEQ_IDLE) && (!need_reset || new_cmd == `CMD_RESET)
        && (new_cmd != `CMD_AUTOSEL
            || (ready_q && !auto_v[new_bank] && !query_v[new_bank]))
        && (new_cmd != `CMD_QUERY || (ready_q && query_v == '0))
        && (new_cmd != `CMD_WRITE || !any_special)
        && new_cmd <= `CMD_WRITE;
    wire go = wr_ctrl && cmd_ok;

    // bus cycle engine
    wire [38:0] cur = cmd_step(cmd_q, step_q, bank_q, addr_reg, wdata_reg);
    wire eng_write = cur[38];
    wire [`FL_ADDR_W-1:0] eng_addr = cur[37:16];
    wire [`FL_DATA_W-1:0] eng_wdata = cur[15:0];
    wire eng_start = (seq == SEQ_START);
    wire eng_done;
    wire [`FL_DATA_W-1:0] eng_rdata;
    wire [1:0] last_step = (cmd_q == `CMD_AUTOSEL) ? 2'h2 : 2'h0;
    wire seq_done = (seq == SEQ_WAIT) && eng_done && step_q == last_step;
    wire done_reset = seq_done && cmd_q == `CMD_RESET;
    wire done_autosel = seq_done && cmd_q == `CMD_AUTOSEL;
    wire done_query = seq_done && cmd_q == `CMD_QUERY;
    wire done_read = seq_done && cmd_q == `CMD_READ;
    wire done_write = seq_done && cmd_q == `CMD_WRITE;
    wire [1:0] addr_bank = addr_reg[`BANK_LSB +: 2];
    wire [31:0] qexp = query_expect(addr_reg[7:0]);
    wire q_bad = query_v[addr_bank] && addr_reg[`FL_ADDR_W-1:8] == '0
        && ((eng_rdata & qexp[31:16]) != qexp[15:0]);

    flash_bus_cycle u_cycle (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .start_in(eng_start),
        .write_in(eng_write),
        .addr_in(eng_addr),
        .wdata_in(eng_wdata),
        .busy_out(),
        .done_out(eng_done),
        .rdata_out(eng_rdata),
        .fl_addr_out(fl_addr_out),
        .fl_ce_n_out(fl_ce_n_out),
        .fl_we_n_out(fl_we_n_out),
        .fl_oe_n_out(fl_oe_n_out),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe_out(fl_dq_oe_out),
        .fl_dq_in(fl_dq_in)
    );

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            rdy_s1 <= fl_ready_in;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
            if (rdy_s2 == rdy_s3)
                ready_q <= rdy_s3;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            seq <= SEQ_IDLE;
            cmd_q <= `CMD_READ;
            bank_q <= 2'h0;
            step_q <= 2'h0;
        end
        else
        begin
            case (seq)
                SEQ_IDLE:
                    if (go)
                    begin
                        cmd_q <= new_cmd;
                        bank_q <= new_bank;
                        step_q <= 2'h0;
                        seq <= SEQ_START;
                    end
                SEQ_START:
                    seq <= SEQ_WAIT;
                SEQ_WAIT:
                    if (eng_done)
                    begin
                        step_q <= 2'(step_q + 2'h1);
                        seq <= (step_q == last_step) ? SEQ_IDLE : SEQ_START;
                    end
                default:
                    seq <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            need_reset <= 1'b0;
            refused <= 1'b0;
            sig_err <= 1'b0;
        end
        else
        begin
            if (wr_addr)
                addr_reg <= bus_wdata_in[`FL_ADDR_W-1:0];
            if (wr_wdata)
                wdata_reg <= bus_wdata_in[`FL_DATA_W-1:0];
            if (done_read)
                rdata_reg <= eng_rdata;
            // timeout seen while busy blocks all but reset
            if (done_read && !ready_q && eng_rdata[`TIMEOUT_BIT])
                need_reset <= 1'b1;
            else if (done_reset)
                need_reset <= 1'b0;
            // sticky flags: a new event beats a clear
            if (wr_ctrl && !cmd_ok)
                refused <= 1'b1;
            else if (wr_status && bus_wdata_in[`ST_REFUSED])
                refused <= 1'b0;
            // signature and table check in query mode
            if (done_read && q_bad)
                sig_err <= 1'b1;
            else if (wr_status && bus_wdata_in[`ST_SIG_ERR])
                sig_err <= 1'b0;
        end
    end

    for (genvar b = 0; b < NB; b++)
    begin : g_bank
        bank_mode_e mode;
        logic prev_auto;
        assign auto_v[b] = (mode == MODE_AUTOSEL);
        assign query_v[b] = (mode == MODE_QUERY);
        always_ff @(posedge ref_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                mode <= MODE_READ;
                prev_auto <= 1'b0;
                susp_v[b] <= 1'b0;
            end
            else
            begin
                // query exit goes back to autoselect if entered there
                if (done_reset)
                    mode <= (query_v[b] && prev_auto) ? MODE_AUTOSEL
                                                      : MODE_READ;
                else if (done_query)
                begin
                    prev_auto <= auto_v[b];
                    mode <= MODE_QUERY;
                end
                else if (done_autosel && bank_q == 2'(b))
                    mode <= MODE_AUTOSEL;
                // suspend survives reset, bank returns to suspend-read
                if (done_write && addr_bank == 2'(b))
                begin
                    if (wdata_reg == `FL_SUSPEND_DATA)
                        susp_v[b] <= 1'b1;
                    else if (wdata_reg == `FL_RESUME_DATA)
                        susp_v[b] <= 1'b0;
                end
            end
        end
    end

    wire [31:0] status_word = {12'h000, susp_v, query_v, auto_v, 3'h0,
        sig_err, refused, need_reset, ready_q, seq != SEQ_IDLE};
    wire [31:0] rd_mux =
        (bus_addr_in == `REG_ADDR) ? {10'h000, addr_reg} :
        (bus_addr_in == `REG_WDATA) ? {16'h0000, wdata_reg} :
        (bus_addr_in == `REG_STATUS) ? status_word :
        (bus_addr_in == `REG_RDATA) ? {16'h0000, rdata_reg} :
        (bus_addr_in == `REG_CTRL) ? {26'h0, bank_q, 1'b0, cmd_q} :
        32'h00000000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            bus_rdata_out <= 32'h00000000;
        else
            bus_rdata_out <= bus_rd_in ? rd_mux : 32'h00000000;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_unlock1;
        eng_start && cmd_q == `CMD_AUTOSEL && eng_addr == `FL_UNLOCK1_ADDR
            && eng_wdata == `FL_UNLOCK1_DATA;
    endsequence
    sequence s_unlock_rest;
        ##[1:40] (eng_start && eng_addr == `FL_UNLOCK2_ADDR
            && eng_wdata == `FL_UNLOCK2_DATA)
        ##[1:40] (eng_start && eng_wdata == `FL_AUTOSEL_DATA
            && eng_addr[`BANK_LSB +: 2] == bank_q);
    endsequence

    a_reset_only_after: assert property (
        need_reset && eng_start |-> cmd_q == `CMD_RESET)
        else $error("non-reset command sent while reset is owed");
    a_autosel_entry_ok: assert property (
        eng_start && cmd_q == `CMD_AUTOSEL && step_q == 2'h0
            |-> ready_q && !auto_v[bank_q] && !query_v[bank_q])
        else $error("autoselect issued to a busy or non-read bank");
    a_autosel_sequence: assert property (
        s_unlock1 |-> s_unlock_rest)
        else $error("autoselect cycles out of order");
    a_sector_read_addr: assert property (
        eng_start && cmd_q == `CMD_READ |=> !fl_ce_n_out && fl_we_n_out
            && fl_addr_out == addr_reg)
        else $error("read lost bank or sector address bits");
    a_query_entry_cycle: assert property (
        eng_start && cmd_q == `CMD_QUERY |-> eng_write && ready_q
            && eng_addr == `FL_QUERY_ADDR && eng_wdata == `FL_QUERY_DATA)
        else $error("query entry malformed or device not ready");
    a_query_exit_mode: assert property (
        done_reset |=> query_v == '0 && $stable(susp_v))
        else $error("reset did not leave query mode");
endmodule // flash_host_ctrl
`default_nettype wire

//--- pkg/flash_host_consts.svh
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// register port map
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA 8'h10

// ctrl fields and command codes
`define CTRL_BANK_LSB 4
`define CMD_READ 3'h0
`define CMD_RESET 3'h1
`define CMD_AUTOSEL 3'h2
`define CMD_QUERY 3'h3
`define CMD_WRITE 3'h4

// status fields
`define ST_BUSY 0
`define ST_READY 1
`define ST_NEED_RESET 2
`define ST_REFUSED 3
`define ST_SIG_ERR 4
`define ST_AUTOSEL_LSB 8
`define ST_QUERY_LSB 12
`define ST_SUSP_LSB 16

// flash geometry
`define FL_ADDR_W 22
`define FL_DATA_W 16
`define NUM_BANKS 4
`define BANK_LSB 20
`define TIMEOUT_BIT 5

// flash command words
`define FL_UNLOCK1_ADDR 22'h000555
`define FL_UNLOCK1_DATA 16'h00aa
`define FL_UNLOCK2_ADDR 22'h0002aa
`define FL_UNLOCK2_DATA 16'h0055
`define FL_AUTOSEL_DATA 16'h0090
`define FL_QUERY_ADDR 22'h000055
`define FL_QUERY_DATA 16'h0098
`define FL_RESET_DATA 16'h00f0
`define FL_SUSPEND_DATA 16'h00b0
`define FL_RESUME_DATA 16'h0030

// pin timing
`define CLK_PERIOD_NS 50
`define STEP_NS 100
`define STEP_CYCLES ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_STEPS 2

`endif

//--- pkg/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
    typedef enum logic [2:0] {
        MODE_READ = 3'b001,
        MODE_AUTOSEL = 3'b010,
        MODE_QUERY = 3'b100
    } bank_mode_e;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_START = 3'b010,
        SEQ_WAIT = 3'b100
    } seq_state_e;
    typedef enum logic [3:0] {
        CYC_IDLE = 4'b0001,
        CYC_SETUP = 4'b0010,
        CYC_STROBE = 4'b0100,
        CYC_HOLD = 4'b1000
    } cyc_state_e;
endpackage
`default_nettype wire

//--- sim/flash_dev_model.sv
`include "flash_host_consts.svh"
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    // arbitrary value standing for any identifier word
    parameter logic [15:0] ID_WORD = 16'h1234
)
(
    // flash pins
    input wire logic [`FL_ADDR_W-1:0] addr_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [`FL_DATA_W-1:0] dq_in,
    output logic [`FL_DATA_W-1:0] dq_out,
    // bench control
    input wire logic timeout_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PRI [0:27] = '{
        16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0004,
        16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0077, 16'h0000,
        16'h0000, 16'h0085, 16'h0095, 16'h0001, 16'h0001, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004,
        16'h0017, 16'h0030, 16'h0030, 16'h0017};
    logic [`FL_ADDR_W-1:0] lat_addr = '0;
    logic [15:0] last = '0;
    logic [1:0] step = '0;
    logic [3:0] autosel = '0;
    logic query = 1'b0;
    logic wr_on = 1'b0;
    wire logic in_pri = addr_in[7:0] inside {[8'h40:8'h5b]};
    wire logic [4:0] pri_idx = 5'(addr_in[7:0] - 8'h40);
    task automatic take(input logic [21:0] a, input logic [15:0] d);
        if (d == `FL_RESET_DATA)
        begin
            if (!query)
                autosel = '0;
            query = 1'b0;
            step = '0;
        end
        else if (step == 0 && a == `FL_UNLOCK1_ADDR && d == `FL_UNLOCK1_DATA)
            step = 2'h1;
        else if (step == 1 && a == `FL_UNLOCK2_ADDR && d == `FL_UNLOCK2_DATA)
            step = 2'h2;
        else if (step == 2 && a[19:0] == 20'h555 && d == `FL_AUTOSEL_DATA)
        begin
            autosel[a[21:20]] = 1'b1;
            step = '0;
        end
        else if (a == `FL_QUERY_ADDR && d == `FL_QUERY_DATA)
            query = 1'b1;
        else
            step = '0;
        if (d == `FL_RESET_DATA)
            step = '0;
    endtask
    always @(negedge ce_n_in or negedge we_n_in)
        if (!ce_n_in && !we_n_in && oe_n_in)
        begin
            lat_addr = addr_in;
            wr_on = 1'b1;
        end
    always @(posedge ce_n_in or posedge we_n_in)
        if (wr_on)
        begin
            wr_on = 1'b0;
            take(lat_addr, dq_in);
        end
    // released bus shows inverse of last word, never a stale copy
    always @*
        if (!ce_n_in && !oe_n_in)
        begin
            if (timeout_in)
                dq_out = 16'h0020;
            else if (query)
                dq_out = in_pri ? PRI[pri_idx] : 16'h0000;
            else if (autosel[addr_in[21:20]])
                dq_out = ID_WORD;
            else
                dq_out = addr_in[15:0] ^ 16'h3c5a;
            last = dq_out;
        end
        else
            dq_out = ~last;
endmodule // flash_dev_model
`default_nettype wire

//--- sim/tb_top.sv
`include "flash_host_consts.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic fl_ready = 1'b1;
    logic timeout = 1'b0;
    logic [31:0] bus_rdata;
    logic [21:0] fl_addr;
    logic fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe;
    logic [15:0] fl_dq_w, model_dq;
    int fails = 0;
    int check_count = 0;
    // shared data line: host wins only while it enables its driver
    wire logic [15:0] dq_wire = fl_dq_oe ? fl_dq_w : model_dq;
    flash_host_ctrl flash_host_ctrl_i (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata),
        .bus_wr_in(bus_wr), .bus_rd_in(bus_rd),
        .bus_rdata_out(bus_rdata), .fl_addr_out(fl_addr),
        .fl_ce_n_out(fl_ce_n), .fl_we_n_out(fl_we_n),
        .fl_oe_n_out(fl_oe_n), .fl_dq_out(fl_dq_w),
        .fl_dq_oe_out(fl_dq_oe), .fl_dq_in(dq_wire),
        .fl_ready_in(fl_ready));
    flash_dev_model flash_dev_model_i (
        .addr_in(fl_addr), .ce_n_in(fl_ce_n), .we_n_in(fl_we_n),
        .oe_n_in(fl_oe_n), .dq_in(dq_wire), .dq_out(model_dq),
        .timeout_in(timeout));
    initial
        forever #25 ref_clk_in = ~ref_clk_in;
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk_in);
        bus_wr <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk_in);
        bus_rd <= 1'b0;
        @(posedge ref_clk_in);
        d = bus_rdata;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [1:0] b);
        logic [31:0] s;
        wr(`REG_CTRL, {26'h0, b, 1'b0, c});
        for (int n = 0; n < 40; n++)
        begin
            rd(`REG_STATUS, s);
            if (s[`ST_BUSY] === 1'b0)
                return;
        end
        check("busy", s, 32'h0);
    endtask
    task automatic fread(input logic [21:0] a, output logic [31:0] d);
        wr(`REG_ADDR, {10'h0, a});
        cmd(`CMD_READ, 2'h0);
        rd(`REG_RDATA, d);
    endtask
    task automatic reset_values;
        logic [31:0] d;
        rd(`REG_STATUS, d);
        check("status", d, 32'h2);
        rd(8'h20, d);
        check("unmapped", d, 32'h0);
        fread(22'h012345, d);
        check("array", d, 32'h1f1f);
    endtask
    task automatic query_table;
        logic [31:0] d;
        logic [15:0] e;
        cmd(`CMD_QUERY, 2'h0);
        rd(`REG_STATUS, d);
        check("query bits", d[15:12], 4'hf);
        for (int i = 0; i < 28; i++)
        begin
            if (i > 16 && i < 23)
                continue;
            e = flash_dev_model_i.PRI[i];
            fread(22'(64 + i), d);
            check("cfi", d[15:0], e);
        end
        rd(`REG_STATUS, d);
        check("sig_err", d[`ST_SIG_ERR], 1'b0);
        // status word in place of the signature must be flagged
        timeout <= 1'b1;
        fread(22'h000040, d);
        timeout <= 1'b0;
        rd(`REG_STATUS, d);
        check("sig_err set", d[`ST_SIG_ERR], 1'b1);
        wr(`REG_STATUS, 32'h10);
        cmd(`CMD_RESET, 2'h0);
        rd(`REG_STATUS, d);
        check("query exit", d, 32'h2);
    endtask
    task automatic autosel_modes;
        logic [31:0] d;
        cmd(`CMD_AUTOSEL, 2'h2);
        rd(`REG_STATUS, d);
        check("autosel", d[11:8], 4'h4);
        fread(22'h212345, d);
        check("id", d, 32'h1234);
        fread(22'h012345, d);
        check("other bank", d, 32'h1f1f);
        cmd(`CMD_WRITE, 2'h0);
        rd(`REG_STATUS, d);
        check("refused", d[`ST_REFUSED], 1'b1);
        wr(`REG_STATUS, 32'h8);
        cmd(`CMD_QUERY, 2'h0);
        cmd(`CMD_RESET, 2'h0);
        rd(`REG_STATUS, d);
        check("back to autosel", d[15:8], 8'h04);
        cmd(`CMD_RESET, 2'h0);
        rd(`REG_STATUS, d);
        check("read again", d, 32'h2);
    endtask
    task automatic timeout_reset;
        logic [31:0] d;
        fl_ready <= 1'b0;
        timeout <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        fread(22'h0, d);
        rd(`REG_STATUS, d);
        check("need reset", d[`ST_NEED_RESET], 1'b1);
        cmd(`CMD_AUTOSEL, 2'h1);
        rd(`REG_STATUS, d);
        check("owed", d[`ST_REFUSED], 1'b1);
        wr(`REG_STATUS, 32'h8);
        timeout <= 1'b0;
        fl_ready <= 1'b1;
        cmd(`CMD_RESET, 2'h0);
        repeat (6) @(posedge ref_clk_in);
        rd(`REG_STATUS, d);
        check("after reset", d, 32'h2);
    endtask
    task automatic suspend_keep;
        logic [31:0] d;
        wr(`REG_WDATA, 32'(`FL_SUSPEND_DATA));
        wr(`REG_ADDR, 32'h100000);
        cmd(`CMD_WRITE, 2'h1);
        cmd(`CMD_RESET, 2'h1);
        rd(`REG_STATUS, d);
        check("suspend kept", d[19:16], 4'h2);
        wr(`REG_WDATA, 32'(`FL_RESUME_DATA));
        cmd(`CMD_WRITE, 2'h1);
        rd(`REG_STATUS, d);
        check("resumed", d, 32'h2);
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        // synchroniser needs a few edges before ready shows
        repeat (8) @(posedge ref_clk_in);
        reset_values();
        query_table();
        autosel_modes();
        timeout_reset();
        suspend_keep();
        final_report();
    end
    initial
    begin
        repeat (30000) @(posedge ref_clk_in);
        fails++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
